// [hdl/lsel_enable.sv]
// Purpose: Combines shutter switch, remote shutter request and remote
//          interlock into RF driver power, lasing enable and status
// Assumes: Inputs may be asynchronous to clk; resetRequest is the off/on reset
// Notes:   keyswitchFitted selects delay and latched interlock faults
//
// Function
// - Lase only with shutter switch open
// - Shutter lamp lit exactly when RF powered
// - Request plus open switch powers RF driver
// - Keyswitch: wait five seconds after shutter output
// - Inhibit unless switch open and request asserted
// - Shutter contact closes only with both conditions
// - Interlock green permits; removal red, ready off
// - RF power needs green, ready and shutter together
// - Keyswitch: five seconds after interlock asserts
// - Interlock loss cuts RF until reasserted
// - Interlock contact closed while interlock open
// - No keyswitch: no fault latch, immediate re-enable
// - Keyswitch: latch fault until off-on reset
`timescale 1ns/1ns

module lsel_enable #(
  parameter int unsigned DELAY_CYC = lsel_pkg::DELAY_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Configuration
  input  wire logic                   keyswitchFitted,
  // Safety inputs
  input  wire lsel_pkg::lsel_inputs_t safetyIn,
  // Indicators and drive
  output logic                        rfPowerEn,
  output logic                        laseEn,
  output lsel_pkg::lsel_lamps_t       lamps,
  output lsel_pkg::lsel_status_t      status
);
  import lsel_pkg::*;

  localparam logic [DELAY_W-1:0] DELAY_LAST = DELAY_W'(DELAY_CYC - 1);

  // States in which DC power reaches the RF driver
  function automatic logic isPowered(input lsel_state_t s);
    return (s == LSEL_LASE) || (s == LSEL_WAIT);
  endfunction

  // Synchroniser chains, one per input bit
  logic [SYNC_STAGES-1:0] syncQ [4];
  lsel_inputs_t           syncIn;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gSync
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          syncQ[g] <= '0;
        end else begin
          syncQ[g] <= {syncQ[g][SYNC_STAGES-2:0], safetyIn[g]};
        end
      end
      assign syncIn[g] = syncQ[g][SYNC_STAGES-1];
      // Each bit reaches the decision exactly two edges late
      a_sync_delay: assert property (@(posedge clk) disable iff (!resetn)
        ($past(resetn) && $past(resetn, 2))
        |-> syncIn[g] == $past(safetyIn[g], 2))
        else $error("synchroniser latency wrong");
    end
  endgenerate

  // Enable conditions
  logic shutterOk;
  logic interlockOk;
  logic allOk;
  assign shutterOk   = syncIn.shutterSwitchOpen && syncIn.shutterReq;
  assign interlockOk = syncIn.interlockIn;
  assign allOk       = shutterOk && interlockOk && !syncIn.resetRequest;

  // Sequencer state
  lsel_state_t        state_q, state_d;
  logic [DELAY_W-1:0] count_q, count_d;
  logic               rdyArm_q, rdyArm_d;

  // Next state: delay, fault latch, re-arm by reset pulse
  always_comb begin
    state_d  = state_q;
    count_d  = count_q;
    rdyArm_d = rdyArm_q;
    if (syncIn.resetRequest) begin
      rdyArm_d = 1'b1;
    end
    case (state_q)
      LSEL_IDLE: begin
        count_d = '0;
        if (allOk && (!keyswitchFitted || rdyArm_q)) begin
          state_d = keyswitchFitted ? LSEL_WAIT : LSEL_LASE;
        end
      end
      LSEL_WAIT: begin
        if (!interlockOk) begin
          state_d = LSEL_FAULT;
          count_d = '0;
        end else if (!allOk) begin
          state_d = LSEL_IDLE;
          count_d = '0;
        end else if (count_q == DELAY_LAST) begin
          state_d = LSEL_LASE;
        end else begin
          count_d = count_q + 1'b1;
        end
      end
      LSEL_LASE: begin
        if (!interlockOk) begin
          state_d = keyswitchFitted ? LSEL_FAULT : LSEL_IDLE;
        end else if (!allOk) begin
          state_d = LSEL_IDLE;
        end
      end
      LSEL_FAULT: begin
        rdyArm_d = syncIn.resetRequest;
        if (syncIn.resetRequest) begin
          state_d = LSEL_IDLE;
        end
      end
      default: begin
        state_d = LSEL_IDLE;
      end
    endcase
    if (state_d == LSEL_FAULT) begin
      rdyArm_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= LSEL_IDLE;
      count_q  <= '0;
      rdyArm_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      count_q  <= count_d;
      rdyArm_q <= rdyArm_d;
    end
  end

  // Output next values
  logic           rfPower_d;
  logic           laseEn_d;
  lsel_lamps_t    lamps_d;
  lsel_status_t   status_d;
  always_comb begin
    rfPower_d = isPowered(state_d);
    laseEn_d  = (state_d == LSEL_LASE);
    lamps_d.shutterIndicator = rfPower_d;
    lamps_d.readyIndicator   = rfPower_d;
    lamps_d.interlockGreen   = interlockOk;
    lamps_d.interlockRed     = !interlockOk;
    status_d.shutterOpenOut   = 1'b0;
    status_d.shutterOpenOe    = shutterOk;
    status_d.interlockOpenOut = 1'b0;
    status_d.interlockOpenOe  = !interlockOk;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rfPowerEn <= 1'b0;
      laseEn    <= 1'b0;
      lamps     <= '0;
      status    <= '0;
    end else begin
      rfPowerEn <= rfPower_d;
      laseEn    <= laseEn_d;
      lamps     <= lamps_d;
      status    <= status_d;
    end
  end

  // Checks
  a_lase_needs_switch: assert property (@(posedge clk) disable iff (!resetn)
    laseEn |-> $past(syncIn.shutterSwitchOpen))
    else $error("lasing without open shutter switch");
  a_lamp_tracks_rf: assert property (@(posedge clk) disable iff (!resetn)
    lamps.shutterIndicator == rfPowerEn)
    else $error("shutter lamp differs from RF power");
  a_req_powers_rf: assert property (@(posedge clk) disable iff (!resetn)
    (allOk && !keyswitchFitted && state_q == LSEL_IDLE) |=> rfPowerEn)
    else $error("request did not power RF driver");
  a_lase_needs_both: assert property (@(posedge clk) disable iff (!resetn)
    laseEn |-> $past(shutterOk))
    else $error("lasing without both shutter conditions");
  a_shut_contact: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> status.shutterOpenOe == $past(shutterOk))
    else $error("shutter contact wrong");
  a_ilk_lamps: assert property (@(posedge clk) disable iff (!resetn)
    lamps.interlockRed |-> !lamps.readyIndicator)
    else $error("ready lit with interlock red");
  a_rf_needs_all: assert property (@(posedge clk) disable iff (!resetn)
    rfPowerEn |-> lamps.interlockGreen && lamps.readyIndicator)
    else $error("RF powered without all lamps");
  a_ks_no_early: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == LSEL_IDLE && keyswitchFitted) |=> !laseEn[*2])
    else $error("lasing before delay");
  a_ilk_cuts_rf: assert property (@(posedge clk) disable iff (!resetn)
    !interlockOk |=> !rfPowerEn)
    else $error("RF kept after interlock loss");
  a_ilk_contact: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> status.interlockOpenOe == $past(!interlockOk))
    else $error("interlock contact wrong");
  a_ks_latch: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == LSEL_FAULT && !syncIn.resetRequest) |=> state_q == LSEL_FAULT)
    else $error("fault left without reset");
  a_cnt_restart: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == LSEL_WAIT && !allOk) |=> count_q == '0)
    else $error("delay count not restarted");

  // Outputs mirror the registered state one for one
  a_rf_from_state: assert property (@(posedge clk) disable iff (!resetn)
    rfPowerEn == isPowered(state_q))
    else $error("RF power differs from state");
  a_lase_from_state: assert property (@(posedge clk) disable iff (!resetn)
    laseEn == (state_q == LSEL_LASE))
    else $error("lasing differs from state");
  a_ready_lamp: assert property (@(posedge clk) disable iff (!resetn)
    lamps.readyIndicator == rfPowerEn)
    else $error("ready lamp differs from RF power");

  // Interlock lamp shows exactly one colour once out of reset
  a_ilk_lamp_pair: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> lamps.interlockGreen != lamps.interlockRed)
    else $error("interlock lamp colours not complementary");

  // A held reset request keeps the driver unpowered
  a_reset_inhibits: assert property (@(posedge clk) disable iff (!resetn)
    syncIn.resetRequest |=> !rfPowerEn && !laseEn)
    else $error("RF powered during reset request");

  // Delay counter: cleared while idle, steps by one while waiting
  a_count_idle: assert property (@(posedge clk) disable iff (!resetn)
    state_q == LSEL_IDLE |=> count_q == '0)
    else $error("delay count not cleared in idle");
  a_count_step: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == LSEL_WAIT && allOk && count_q != DELAY_LAST)
    |=> count_q == $past(count_q) + 1'b1)
    else $error("delay count did not step");

  // Fault always drops the arm, so a fresh reset pulse is needed
  a_fault_disarms: assert property (@(posedge clk) disable iff (!resetn)
    state_q == LSEL_FAULT |-> !rdyArm_q)
    else $error("arm kept through fault");
  a_unarmed_idle: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == LSEL_IDLE && keyswitchFitted && !rdyArm_q &&
     !syncIn.resetRequest) |=> state_q == LSEL_IDLE)
    else $error("left idle without arm");

  // Steps of the enable sequence
  sequence s_armed_go;
    state_q == LSEL_IDLE && keyswitchFitted && rdyArm_q && allOk;
  endsequence
  sequence s_delay_spent;
    state_q == LSEL_WAIT && allOk && count_q == DELAY_LAST;
  endsequence
  sequence s_lost_lasing;
    state_q == LSEL_LASE && keyswitchFitted && !interlockOk;
  endsequence
  sequence s_nokey_go;
    state_q == LSEL_IDLE && !keyswitchFitted && allOk;
  endsequence

  // Armed keyswitch unit powers the driver and starts the delay
  property p_arm_to_wait;
    @(posedge clk) disable iff (!resetn)
    s_armed_go |=> state_q == LSEL_WAIT && rfPowerEn && !laseEn;
  endproperty
  // Spent delay turns on lasing on the next edge
  property p_wait_to_lase;
    @(posedge clk) disable iff (!resetn)
    s_delay_spent |=> state_q == LSEL_LASE && laseEn;
  endproperty
  // Interlock loss while lasing latches a fault on keyswitch units
  property p_loss_latches;
    @(posedge clk) disable iff (!resetn)
    s_lost_lasing |=> state_q == LSEL_FAULT && !rfPowerEn;
  endproperty
  // Units without keyswitch enable at once
  property p_nokey_direct;
    @(posedge clk) disable iff (!resetn)
    s_nokey_go |=> state_q == LSEL_LASE && laseEn;
  endproperty

  a_arm_to_wait: assert property (p_arm_to_wait)
    else $error("armed unit did not start delay");
  a_wait_to_lase: assert property (p_wait_to_lase)
    else $error("lasing not enabled after delay");
  a_loss_latches: assert property (p_loss_latches)
    else $error("interlock loss did not latch fault");
  a_nokey_direct: assert property (p_nokey_direct)
    else $error("unit without keyswitch did not enable");

endmodule

// [hdl/lsel_pkg.sv]
// Purpose: Shared constants and types for the laser safety enable logic
// Assumes: 20 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package lsel_pkg;

  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned DELAY_S      = 5;
  localparam int unsigned DELAY_CYCLES = DELAY_S * CLK_HZ;
  localparam int unsigned DELAY_W      = 27;
  localparam int unsigned SYNC_STAGES  = 2;

  // Raw safety inputs, taken together
  typedef struct packed {
    logic shutterReq;
    logic interlockIn;
    logic shutterSwitchOpen;
    logic resetRequest;
  } lsel_inputs_t;

  // Indicator lamps
  typedef struct packed {
    logic shutterIndicator;
    logic readyIndicator;
    logic interlockGreen;
    logic interlockRed;
  } lsel_lamps_t;

  // Open-drain style status contacts: value plus enable
  typedef struct packed {
    logic shutterOpenOut;
    logic shutterOpenOe;
    logic interlockOpenOut;
    logic interlockOpenOe;
  } lsel_status_t;

  // Enable sequencing states
  typedef enum logic [1:0] {
    LSEL_IDLE,
    LSEL_WAIT,
    LSEL_LASE,
    LSEL_FAULT
  } lsel_state_t;

endpackage

// [verification/laser_safety_enable_logic_tb.sv]
// Purpose: Self-checking bench for the enable logic, both variants
// Assumes: Delay shortened to 20 cycles; outputs settle within 6 edges
// Notes:   Inputs packed as {request, interlock, switch, reset}
`timescale 1ns/1ns
module laser_safety_enable_logic_tb;
  import lsel_pkg::*;
  logic         clk       = 1'b0;
  logic         resetn    = 1'b0;
  logic         keyFit    = 1'b0;
  lsel_inputs_t sin       = '0;
  logic         rfOn;
  logic         laseOn;
  lsel_lamps_t  lamps;
  lsel_status_t status;
  logic         shutLine;
  logic         ilkLine;
  int           failures  = 0;
  int           numChecks = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  lsel_enable #(.DELAY_CYC(20)) uut (
    .clk(clk), .resetn(resetn), .keyswitchFitted(keyFit),
    .safetyIn(sin), .rfPowerEn(rfOn), .laseEn(laseOn),
    .lamps(lamps), .status(status));
  lsel_plc_model plc (
    .status(status), .shutterLine(shutLine), .interlockLine(ilkLine));

  // Compare drive, lamps and contact lines against an expected pattern
  task automatic chk(input string n, input logic [7:0] e);
    logic [7:0] g;
    g = {rfOn, laseOn, lamps, shutLine, ilkLine};
    numChecks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Apply an input set just after an edge, then let n edges pass
  task automatic drive(input logic [3:0] v, input int n);
    @(posedge clk);
    #5 sin = v;
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Reset held for 8 cycles with the chosen variant
  task automatic doReset(input logic key);
    @(posedge clk);
    #5 resetn = 1'b0;
    keyFit = key;
    sin = '0;
    repeat (8) @(posedge clk);
    #5 resetn = 1'b1;
    drive(4'h0, 6);
    chk("idle", 8'h06);
  endtask

  // Variant without keyswitch: no delay, no fault latch
  task automatic testNoKey;
    doReset(1'b0);
    drive(4'he, 6); chk("allOn", 8'hf9);
    drive(4'hc, 6); chk("switchShut", 8'h0b);
    drive(4'he, 6); chk("reopen", 8'hf9);
    drive(4'h6, 6); chk("noRequest", 8'h0b);
    drive(4'ha, 6); chk("noInterlock", 8'h04);
    drive(4'he, 6); chk("relock", 8'hf9);
    drive(4'hf, 6); chk("inhibit", 8'h09);
  endtask

  // Keyswitch variant: arm, delay, fault latch, delay restart
  task automatic testKey;
    doReset(1'b1);
    drive(4'he, 10); chk("unarmed", 8'h09);
    drive(4'hf, 2);
    drive(4'he, 10); chk("waiting", 8'hb9);
    drive(4'he, 20); chk("lasing", 8'hf9);
    drive(4'ha, 6); chk("ilkLost", 8'h04);
    drive(4'he, 10); chk("latched", 8'h09);
    drive(4'hf, 2);
    drive(4'he, 10); chk("rearmed", 8'hb9);
    drive(4'hc, 8);
    drive(4'he, 12); chk("restart", 8'hb9);
    drive(4'he, 20); chk("lasing2", 8'hf9);
  endtask

  // Print counts and the verdict, then stop
  task automatic give_verdict;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    testNoKey();
    testKey();
    give_verdict();
  end

  // Watchdog well beyond the expected run of some 200 cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule

// [verification/lsel_plc_model.sv]
// Purpose: Control system side, reading the two status contacts
// Assumes: Each contact line has a pull-up at the control system input
// Notes:   A closed contact pulls its line low; open leaves it high
`timescale 1ns/1ns
module lsel_plc_model (
  // Contacts from the laser
  input  wire lsel_pkg::lsel_status_t status,
  // Levels seen at the control system inputs
  output logic                        shutterLine,
  output logic                        interlockLine
);
  import lsel_pkg::*;
  // Pull-up wins unless the contact is closed
  assign shutterLine   = status.shutterOpenOe ? 1'b0 : 1'b1;
  assign interlockLine = status.interlockOpenOe ? 1'b0 : 1'b1;
endmodule
